// [rtl/instr_decode_defines.vh]
`ifndef INSTR_DECODE_DEFINES_VH
`define INSTR_DECODE_DEFINES_VH
// ****************************************
// opcode patterns
// ****************************************
`define OP_TSTSZ_HI   7'h33
`define OP_XORLIT_HI  8'h0a
`define OP_XORREG_HI  6'h06
`define OP_PADD_HI    8'he8
`define OP_PSUB_HI    8'he9
`define OP_PUSH_LITERAL_FRAME_HI   8'hea
`define OP_IMOVE_HI   8'heb
`define OP_CALL_VIA_WORK_REG      16'h0014
`define OP_SECOND_HI  4'hf
`define PTR_FRAME_SEL 2'h3
`define PTR_FRAME_IDX 2'h2
`define IDX_LIMIT     8'h5f
`define ACCESS_SPLIT  8'h60
// indirect-access register window in the top page
`define INDF_LO       12'hfe7
`define INDF_HI       12'hfef
`define PC_STEP       21'h000002
// ****************************************
// state codes
// ****************************************
`define ST_FETCH      2'h0
`define ST_DISCARD    2'h1
`define ST_SECOND     2'h2
`define ST_NOP        2'h3
`endif

// [rtl/instr_decode_exec.v]
// Summary of operation
// - a test-and-skip on a zero register discards the next word as a one-cycle nop, two cycles in total, with no flag change.
// - if the skipped instruction is two words, both are discarded for three cycles in total.
// - operand bit a=0 picks the access bank, a=1 uses the bank select register.
// - with a=0, extension on and operand at most 5fh, the operand is a frame-pointer offset.
// - xor literal puts w^k into w in one cycle, updating only negative and zero.
// - xor register puts w^f into w when d=0 or into f when d=1, updating negative and zero.
// - extended instructions and indexed addressing stay off unless the config bit is set.
// - with the extension on, eight extra instructions are decoded.
// - pointer add and subtract change the selected pointer by k in one cycle, no flags.
// - pointer field 11 acts on the frame pointer and then returns, taking two cycles.
// - 0014h is a two-cycle call through the working register with no flag change.
// - indexed moves are two words and two cycles, second word begins 1111.
// - push literal writes k at the frame pointer and then decrements it.
// - call via work pushes pc+2 then loads pc from the latches and the working register.
// - indexed source hitting an indirect register reads zero, such a destination makes a nop.
// - pointer add and subtract literals are 6-bit unsigned.
`include "instr_decode_defines.vh"
module instr_decode_exec #(
  parameter ADDR_W = 12,
  parameter PC_W   = 21
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              reset_n,
  // configuration
  input  wire              ext_set_config_bit,
  // instruction stream, one word per cycle
  input  wire [15:0]       instr_word,
  input  wire              instr_two_word_next,
  // data memory read port (combinational)
  output reg  [ADDR_W-1:0] rd_addr,
  input  wire [7:0]        rd_data,
  // core context
  input  wire [3:0]        bank_select_reg,
  input  wire [7:0]        pc_high_latch,
  input  wire [4:0]        pc_upper_latch,
  input  wire [PC_W-1:0]   pc_current,
  input  wire [PC_W-1:0]   return_stack_top,
  // results
  output reg  [7:0]        working_register,
  output reg               flag_negative,
  output reg               flag_zero,
  output reg               mem_we,
  output reg  [ADDR_W-1:0] mem_waddr,
  output reg  [7:0]        mem_wdata,
  output reg  [ADDR_W-1:0] pointer0,
  output reg  [ADDR_W-1:0] pointer1,
  output reg  [ADDR_W-1:0] stack_frame_pointer,
  output reg               pc_load,
  output reg  [PC_W-1:0]   pc_target,
  output reg               stack_push,
  output reg  [PC_W-1:0]   stack_push_data,
  output reg               ext_enabled,
  output reg               cycle_busy
);
  // ****************************************
  // decode
  // ****************************************
  reg  [1:0]        state;
  reg  [1:0]        next_state;
  // source address of an indexed move, held over to the second word
  reg  [ADDR_W-1:0] move_saved;
  reg               move_is_ss;
  wire [7:0]  f = instr_word[7:0];
  wire        a_bit = instr_word[8];
  wire        d_bit = instr_word[9];
  wire [5:0]  lit6 = instr_word[5:0];
  wire [1:0]  psel = instr_word[7:6];
  wire        is_tst  = instr_word[15:9] == `OP_TSTSZ_HI;
  wire        is_xorl = instr_word[15:8] == `OP_XORLIT_HI;
  wire        is_xorf = instr_word[15:10] == `OP_XORREG_HI;
  wire        is_padd = ext_enabled && instr_word[15:8] == `OP_PADD_HI;
  wire        is_psub = ext_enabled && instr_word[15:8] == `OP_PSUB_HI;
  wire        is_push = ext_enabled && instr_word[15:8] == `OP_PUSH_LITERAL_FRAME_HI;
  wire        is_imov = ext_enabled && instr_word[15:8] == `OP_IMOVE_HI;
  wire        is_call_via_work_reg = ext_enabled && instr_word == `OP_CALL_VIA_WORK_REG;
  // ****************************************
  // address arithmetic
  // ****************************************
  // indexed mode only exists once the extension is live, so a core
  // with the config bit clear keeps plain access bank decoding
  wire        indexed = !a_bit && ext_enabled && f <= `IDX_LIMIT;
  wire [ADDR_W-1:0] frame_off = stack_frame_pointer + {{(ADDR_W-8){1'b0}}, f};
  wire [ADDR_W-1:0] z_src = stack_frame_pointer + {{(ADDR_W-7){1'b0}}, instr_word[6:0]};
  wire [ADDR_W-1:0] z_dst = stack_frame_pointer + {{(ADDR_W-7){1'b0}}, instr_word[6:0]};
  wire [ADDR_W-1:0] f_dst = instr_word[ADDR_W-1:0];
  wire [7:0]  xor_res = working_register ^ (is_xorl ? f : rd_data);
  wire [ADDR_W-1:0] pval = (psel == 2'h0) ? pointer0 : (psel == 2'h1) ? pointer1 : stack_frame_pointer;
  wire [ADDR_W-1:0] pnew = is_padd ? pval + {{(ADDR_W-6){1'b0}}, lit6} : pval - {{(ADDR_W-6){1'b0}}, lit6};
  // ****************************************
  // indirect window
  // ****************************************
  // fetched reads an indirect-access register
  // reading one would chain a second indirection, so it is masked
  function indf_hit;
    input [ADDR_W-1:0] ad;
    begin
      indf_hit = ad >= `INDF_LO && ad <= `INDF_HI;
    end
  endfunction
  // ****************************************
  // read address
  // ****************************************
  // combinational on purpose: the data memory answers in the same cycle,
  // so a register here would cost every register-operand op a cycle
  always @* begin
    if (state == `ST_SECOND)
      rd_addr = move_saved;
    else if (indexed)
      rd_addr = frame_off;
    else if (!a_bit)
      rd_addr = (f < `ACCESS_SPLIT) ? {{(ADDR_W-8){1'b0}}, f} : {{(ADDR_W-8){1'b1}}, f};
    else
      rd_addr = {bank_select_reg, f};
  end
  // ****************************************
  // execute
  // ****************************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= `ST_FETCH;
      working_register <= 8'h00;
      flag_negative <= 1'b0;
      flag_zero <= 1'b0;
      mem_we <= 1'b0;
      mem_waddr <= {ADDR_W{1'b0}};
      mem_wdata <= 8'h00;
      pointer0 <= {ADDR_W{1'b0}};
      pointer1 <= {ADDR_W{1'b0}};
      stack_frame_pointer <= {ADDR_W{1'b0}};
      pc_load <= 1'b0;
      pc_target <= {PC_W{1'b0}};
      stack_push <= 1'b0;
      stack_push_data <= {PC_W{1'b0}};
      ext_enabled <= 1'b0;
      cycle_busy <= 1'b0;
      move_saved <= {ADDR_W{1'b0}};
      move_is_ss <= 1'b0;
    end else begin
      ext_enabled <= ext_set_config_bit;
      mem_we <= 1'b0;
      pc_load <= 1'b0;
      stack_push <= 1'b0;
      state <= next_state;
      cycle_busy <= next_state != `ST_FETCH;
      case (state)
        `ST_FETCH: begin
          if (is_xorl || is_xorf) begin
            flag_negative <= xor_res[7];
            flag_zero <= xor_res == 8'h00;
            if (is_xorf && d_bit) begin
              mem_we <= 1'b1;
              mem_waddr <= rd_addr;
              mem_wdata <= xor_res;
            end else
              working_register <= xor_res;
          end
          if ((is_padd || is_psub) && psel != `PTR_FRAME_SEL) begin
            if (psel == 2'h0) pointer0 <= pnew;
            else if (psel == 2'h1) pointer1 <= pnew;
            else stack_frame_pointer <= pnew;
          end
          if ((is_padd || is_psub) && psel == `PTR_FRAME_SEL) begin
            stack_frame_pointer <= is_padd ? stack_frame_pointer + {{(ADDR_W-6){1'b0}}, lit6}
                                           : stack_frame_pointer - {{(ADDR_W-6){1'b0}}, lit6};
            pc_load <= 1'b1;
            pc_target <= return_stack_top;
          end
          if (is_push) begin
            mem_we <= 1'b1;
            mem_waddr <= stack_frame_pointer;
            mem_wdata <= f;
            stack_frame_pointer <= stack_frame_pointer - {{(ADDR_W-1){1'b0}}, 1'b1};
          end
          if (is_call_via_work_reg) begin
            stack_push <= 1'b1;
            stack_push_data <= pc_current + `PC_STEP;
            pc_load <= 1'b1;
            pc_target <= {pc_upper_latch, pc_high_latch, working_register};
          end
          if (is_imov) begin
            // source is read in the second cycle, masked there
            move_saved <= z_src;
            move_is_ss <= instr_word[7];
          end
        end
        `ST_SECOND: begin
          // source read now, first word kept its computed address
          if (instr_word[15:12] == `OP_SECOND_HI) begin
            mem_waddr <= move_is_ss ? z_dst : f_dst;
            mem_wdata <= indf_hit(move_saved) ? 8'h00 : rd_data;
            mem_we <= !(move_is_ss && indf_hit(z_dst));
          end
        end
        default: begin
          // discarded words change nothing
        end
      endcase
    end
  end
  // ****************************************
  // next state
  // ****************************************
  // the caller flags a two-word successor; the core cannot see it yet
  // when the skip decision is made
  always @* begin
    next_state = `ST_FETCH;
    case (state)
      `ST_FETCH: begin
        if (is_tst && rd_data == 8'h00)
          next_state = instr_two_word_next ? `ST_DISCARD : `ST_NOP;
        else if (is_imov)
          next_state = `ST_SECOND;
        else if (is_call_via_work_reg || ((is_padd || is_psub) && psel == `PTR_FRAME_SEL))
          next_state = `ST_NOP;
      end
      `ST_DISCARD: next_state = `ST_NOP;
      `ST_SECOND:  next_state = `ST_FETCH;
      `ST_NOP:     next_state = `ST_FETCH;
      default:     next_state = `ST_FETCH;
    endcase
  end
endmodule

// [tb/instr_decode_assertions.sv]
module instr_decode_checker (
  input wire logic        ref_clk, reset_n, instr_two_word_next, ext_enabled, cycle_busy,
  input wire logic        flag_negative, flag_zero, mem_we, pc_load, stack_push,
  input wire logic [15:0] instr_word,
  input wire logic [7:0]  rd_data, working_register, mem_wdata,
  input wire logic [11:0] pointer0, stack_frame_pointer, mem_waddr,
  input wire logic [20:0] pc_current, stack_push_data
);
  // ****************************************
  // decode and timing properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire       fetch = !cycle_busy;
  wire [7:0] op    = instr_word[15:8];
  wire       skip  = fetch && instr_word[15:9] == 7'h33 && rd_data == 8'h00;
  wire       ext   = fetch && ext_enabled;
  property p_xor; fetch && op == 8'h0a |=> working_register == ($past(working_register) ^ $past(instr_word[7:0]))
    && flag_zero == (working_register == 8'h00) && flag_negative == working_register[7]; endproperty
  a_xor: assert property (p_xor) else $error("xor literal result wrong");
  property p_skip; skip && !instr_two_word_next |=> cycle_busy && $stable(flag_zero) ##1 !cycle_busy; endproperty
  a_skip: assert property (p_skip) else $error("skip did not take one nop cycle");
  property p_skip2; skip && instr_two_word_next |=> cycle_busy [*2] ##1 !cycle_busy; endproperty
  a_skip2: assert property (p_skip2) else $error("skip over two words did not take two nops");
  property p_discard; skip |-> ##2 !mem_we && !pc_load && !stack_push && $stable(working_register); endproperty
  a_discard: assert property (p_discard) else $error("discarded word had an effect");
  property p_push; ext && op == 8'hea |=> mem_we && mem_wdata == $past(instr_word[7:0])
    && mem_waddr == $past(stack_frame_pointer) && stack_frame_pointer == $past(stack_frame_pointer) - 12'h001; endproperty
  a_push: assert property (p_push) else $error("push literal wrong");
  property p_gate; fetch && !ext_enabled && op[7:4] == 4'he |=> !mem_we && $stable(pointer0); endproperty
  a_gate: assert property (p_gate) else $error("extended opcode acted while disabled");
  property p_padd; ext && op == 8'he8 && instr_word[7:6] == 2'h0 |=> pointer0 == $past(pointer0) + $past(instr_word[5:0])
    && $stable(flag_zero); endproperty
  a_padd: assert property (p_padd) else $error("pointer add wrong");
  property p_ulnk; ext && op[7:1] == 7'h74 && instr_word[7:6] == 2'h3 |=> pc_load && cycle_busy ##1 !cycle_busy; endproperty
  a_ulnk: assert property (p_ulnk) else $error("frame return not two cycles");
  property p_call_via_work_reg; ext && instr_word == 16'h0014 |=> stack_push && pc_load && stack_push_data == $past(pc_current) + 21'h2;
  endproperty
  a_call_via_work_reg: assert property (p_call_via_work_reg) else $error("call via work wrong");
endmodule
bind instr_decode_exec instr_decode_checker i_instr_decode_checker (.*);

// [tb/instr_decode_exec_tb.sv]
module instr_decode_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic        ref_clk = 0, reset_n = 0, ext_set_config_bit = 0, instr_two_word_next = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0]  rd_data = 8'h00, pc_high_latch = 8'h10, working_register, mem_wdata;
  logic [3:0]  bank_select_reg = 4'h3;
  logic [4:0]  pc_upper_latch = 5'h00;
  logic [20:0] pc_current = 21'h000100, return_stack_top = 21'h0abcde, pc_target, stack_push_data;
  logic [11:0] rd_addr, mem_waddr, pointer0, pointer1, stack_frame_pointer;
  logic        flag_negative, flag_zero, mem_we, pc_load, stack_push, ext_enabled, cycle_busy;
  int          n_errors = 0, n_tests = 0;
  instr_decode_exec i_instr_decode_exec (.*);
  initial forever #10 ref_clk = ~ref_clk;
  task complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [8*6:1] name, input [31:0] exp, input [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0s exp %h got %h", name, exp, got);
    end
  endtask
  task op(input [15:0] w);
    @(posedge ref_clk) instr_word <= w;
  endtask
  // idle word, then let the edge's updates land
  task done;
    op(16'h0000);
    #1;
  endtask
  task t_xor;
    op(16'h0ab5); done;
    chk("w", 8'hb5, working_register);
    chk("neg", 1'b1, flag_negative);
    op(16'h19af); rd_data <= 8'haf; done;
    chk("w", 8'h1a, working_register);
    chk("we", 1'b0, mem_we);
    op(16'h1b10); done;
    chk("waddr", 12'h310, mem_waddr);
    chk("wdata", 8'hb5, mem_wdata);
    op(16'h1a80); done;
    chk("waddr", 12'hf80, mem_waddr);
    op(16'h0a1a); done;
    chk("zero", 1'b1, flag_zero);
  endtask
  task t_skip;
    op(16'h6710); rd_data <= 8'h00; op(16'h0aff); op(16'h0a55); done;
    chk("w", 8'h55, working_register);
    op(16'h6710); instr_two_word_next <= 1'b1; op(16'heb05); instr_two_word_next <= 1'b0;
    op(16'hf123); op(16'h0a55); done;
    chk("w", 8'h00, working_register);
    op(16'h6710); rd_data <= 8'h01; op(16'h0a0f); op(16'h0a09); done;
    chk("w", 8'h06, working_register);
  endtask
  task t_ext;
    op(16'hea08); done;
    chk("we", 1'b0, mem_we);
    op(16'h0000); ext_set_config_bit <= 1'b1; done;
    chk("ext", 1'b1, ext_enabled);
    op(16'he823); op(16'he903); done;
    chk("p0", 12'h020, pointer0);
    op(16'he8a3); op(16'hea08); done;
    chk("sfp", 12'h022, stack_frame_pointer);
    chk("waddr", 12'h023, mem_waddr);
    chk("wdata", 8'h08, mem_wdata);
    op(16'he941); done;
    chk("p1", 12'hfff, pointer1);
    op(16'h0014); done;
    chk("push", 21'h000102, stack_push_data);
    chk("target", 21'h001006, pc_target);
    op(16'he8c1); done;
    chk("target", 21'h0abcde, pc_target);
    chk("sfp", 12'h023, stack_frame_pointer);
    op(16'heb05); rd_data <= 8'h33; op(16'hf123); done;
    chk("we", 1'b1, mem_we);
    chk("waddr", 12'h123, mem_waddr);
    chk("wdata", 8'h33, mem_wdata);
    chk("raddr", 12'h023, rd_addr);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_xor;
    t_skip;
    t_ext;
    complete_run;
  end
endmodule
